// ===== hdl/vac_motion.sv
// valve actuator positioner, pulse timer, display sleep and shutdown latch
//
// Summary of operation
// - proportional band 0.1 to 100 percent, default 15
// - dead band stops motion, default 2 percent
// - polarity selects 20 mA as open or closed
// - command loss: open, close, stop or preset
// - stop delay 0 to 60 s before moving
// - follow command, pulse near set-point
// - end zones driven straight without pulsing; here an enabled pulse timer still pulses them inside its region
// - pulse timer enabled per direction
// - pulse region limited to 99 percent travel
// - run time 0.5 to 20 s, half-second steps
// - pause time 1 to 200 s, one-second steps
// - open and close speeds set independently
// - ride-through only after one hour powered
// - on stored energy, display sleeps after idle
// - knob open or handwheel wakes the display
// - redundant pairs act only when both active
// - shutdown pulse without stroke enable latches shutdown
// - ignore under 100 ms, latch past 800 ms
// - latch holds until release given
// - both release inputs clear the latch
// - faulted release pair never clears latch
// - release pair ignored during stroke test
//
// Our own choices: the placing of the registers and register access over Wishbone.
`default_nettype none
module vac_motion
  import vac_pkg::*;
#(
  parameter int MS_CYC  = MS_CYC_DEF,
  parameter int HOUR_MS = HOUR_MS_DEF
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [31:0] dat_i,
  output var  logic [31:0] dat_o,
  input  wire logic        we_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output var  logic        ack_o,
  input  wire logic [9:0]  cmd_i,
  input  wire logic        cmd_ok_i,
  input  wire logic [9:0]  pos_i,
  input  wire logic        esd_mom_i,
  input  wire logic        psd_en_a_i,
  input  wire logic        psd_en_b_i,
  input  wire logic        rel_a_i,
  input  wire logic        rel_b_i,
  input  wire logic        knob_open_i,
  input  wire logic        handwheel_i,
  input  wire logic        line_power_i,
  output var  logic        drive_open_o,
  output var  logic        drive_close_o,
  output var  logic [7:0]  speed_o,
  output var  logic        display_on_o,
  output var  logic        status_hold_o,
  output var  logic        esd_active_o,
  output var  logic        psd_test_o
);

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    for (int i = 0; i < 4; i++) wmerge[8*i+:8] = s[i] ? n[8*i+:8] : o[8*i+:8];
  endfunction

  function automatic logic [9:0] clamp(input logic [9:0] v, input logic [9:0] lo,
                                       input logic [9:0] hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  logic [7:0]  s1, s2;
  logic        esd_s, psd_a_s, psd_b_s, rel_a_s, rel_b_s, knob_s, hand_s, line_s;
  logic [7:0]  ctrl, spd_open, spd_close;
  logic [9:0]  pband, dband, preset, dly, plim, pon, poff, sleep, mism;
  logic [31:0] rdv, wd;
  logic        req, wr;
  logic [15:0] ms_cnt;
  logic        ms_tick;
  vac_state_t  state, next_state;
  logic        dir, next_dir;
  logic [17:0] tmr, on_ms, off_ms;
  logic [9:0]  tgt;
  logic signed [10:0] err, aerr;
  logic        hold, ext, approach, tst, pulsed, want_o, want_c, want_d;
  logic [9:0]  esd_cnt;
  logic        esd_hit, esd_latch, psd_test, psd_ok, rel_ok;
  logic [1:0]  pa, pb, fault;
  logic [9:0]  mis_cnt [2];
  logic [21:0] pwr_cnt;
  logic        ride_ok, wake;
  logic [9:0]  pos_q;
  logic [17:0] idle_ms;

  // pins come from outside the clock domain
  always_ff @(posedge clk_i) begin
    s1 <= {line_power_i, handwheel_i, knob_open_i, rel_b_i, rel_a_i,
           psd_en_b_i, psd_en_a_i, esd_mom_i};
    s2 <= s1;
  end
  assign {line_s, hand_s, knob_s, rel_b_s, rel_a_s, psd_b_s, psd_a_s, esd_s} = s2;

  // wishbone slave: one wait state, unmapped reads zero, writes dropped
  assign req = cyc_i && stb_i && !ack_o;
  assign wr  = req && we_i;
  assign wd  = wmerge(rdv, dat_i, sel_i);

  always_comb begin
    case (adr_i)
      A_CTRL:   rdv = {24'h000000, ctrl};
      A_PBAND:  rdv = {22'h000000, pband};
      A_DBAND:  rdv = {22'h000000, dband};
      A_PRESET: rdv = {22'h000000, preset};
      A_DELAY:  rdv = {22'h000000, dly};
      A_PLIM:   rdv = {22'h000000, plim};
      A_PON:    rdv = {22'h000000, pon};
      A_POFF:   rdv = {22'h000000, poff};
      A_SPEED:  rdv = {16'h0000, spd_close, spd_open};
      A_SLEEP:  rdv = {22'h000000, sleep};
      A_MISM:   rdv = {22'h000000, mism};
      A_STATUS: rdv = {6'h00, pos_i, 8'h00, esd_latch, psd_test, fault, ride_ok,
                       display_on_o, drive_close_o, drive_open_o};
      default:  rdv = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= req;
      if (req) dat_o <= rdv;
    end
  end

  // settings clamp to their legal ranges on write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= CTRL_DEF;
      pband     <= PB_DEF;
      dband     <= DB_DEF;
      preset    <= ZERO;
      dly       <= ZERO;
      plim      <= PLIM_MAX;
      pon       <= ON_MIN;
      poff      <= OFF_MIN;
      spd_open  <= 8'hff;
      spd_close <= 8'hff;
      sleep     <= SLEEP_DEF;
      mism      <= MISM_DEF;
    end else if (wr) begin
      case (adr_i)
        A_CTRL:   ctrl   <= wd[7:0];
        A_PBAND:  pband  <= clamp(wd[9:0], PB_MIN, FULL);
        A_DBAND:  dband  <= clamp(wd[9:0], ZERO, FULL);
        A_PRESET: preset <= clamp(wd[9:0], ZERO, FULL);
        A_DELAY:  dly    <= clamp(wd[9:0], ZERO, DLY_MAX);
        A_PLIM:   plim   <= clamp(wd[9:0], PLIM_MIN, PLIM_MAX);
        A_PON:    pon    <= clamp(wd[9:0], ON_MIN, ON_MAX);
        A_POFF:   poff   <= clamp(wd[9:0], OFF_MIN, OFF_MAX);
        A_SPEED: begin
          spd_open  <= wd[7:0];
          spd_close <= wd[15:8];
        end
        A_SLEEP:  sleep  <= wd[9:0];
        A_MISM:   mism   <= wd[9:0];
        default: ;
      endcase
    end
  end

  // millisecond time base for every timer
  always_ff @(posedge clk_i) begin
    if (rst_i || ms_cnt == 16'(MS_CYC - 1)) ms_cnt <= 16'h0000;
    else ms_cnt <= ms_cnt + 16'h0001;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) ms_tick <= 1'b0;
    else ms_tick <= (ms_cnt == 16'(MS_CYC - 1));
  end

  // target selection and motion demand
  always_comb begin
    tgt  = ctrl[C_POL] ? FULL - cmd_i : cmd_i;
    hold = 1'b0;
    if (esd_latch || psd_test) begin
      case (vac_act_t'(ctrl[C_ESD+:2]))
        ACT_OPEN:  tgt = FULL;
        ACT_CLOSE: tgt = ZERO;
        default:   hold = 1'b1;
      endcase
    end else if (!cmd_ok_i) begin
      case (vac_act_t'(ctrl[C_LOSS+:2]))
        ACT_OPEN:   tgt = FULL;
        ACT_CLOSE:  tgt = ZERO;
        ACT_PRESET: tgt = preset;
        default:    hold = 1'b1;
      endcase
    end
    err  = $signed({1'b0, tgt}) - $signed({1'b0, pos_i});
    aerr = err[10] ? -err : err;
    // shutdown drives straight to its end like an end-zone command
    ext  = (tgt <= EXT_LO) || (tgt >= EXT_HI) || esd_latch || psd_test;
    want_o = !hold && !err[10] && err != 11'sh000
             && (ext || aerr > $signed({1'b0, dband}));
    want_c = !hold && err[10] && (ext || aerr > $signed({1'b0, dband}));
    want_d = dir ? want_o : want_c;
    approach = !ext && aerr < $signed({1'b0, pband});
    tst = ctrl[dir ? C_PO : C_PC] && pos_i >= PLIM_MIN && pos_i <= plim
          && !esd_latch && !psd_test;
    pulsed = approach || tst;
    on_ms  = tst ? 18'(pon) * HALF_MS : APP_ON_MS;
    off_ms = tst ? 18'(poff) * SEC_MS : APP_OFF_MS;
  end

  always_comb begin
    next_state = state;
    next_dir   = dir;
    case (state)
      ST_IDLE: begin
        if (want_o || want_c) begin
          next_state = ST_RUN;
          next_dir   = want_o;
        end
      end
      ST_RUN: begin
        // a reversal always passes through ST_DELAY; the shutdown latch leaves it at once
        if (!want_d) next_state = ST_DELAY;
        else if (pulsed && tmr >= on_ms) next_state = ST_PAUSE;
      end
      ST_PAUSE: begin
        if (!want_d) next_state = ST_DELAY;
        else if (tmr >= off_ms) next_state = ST_RUN;
      end
      ST_DELAY: begin
        // shutdown must not wait out the stop delay
        if (tmr >= 18'(dly) * SEC_MS || esd_latch) next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state         <= ST_IDLE;
      dir           <= 1'b0;
      drive_open_o  <= 1'b0;
      drive_close_o <= 1'b0;
      speed_o       <= 8'h00;
    end else begin
      state         <= next_state;
      dir           <= next_dir;
      drive_open_o  <= next_state == ST_RUN && next_dir;
      drive_close_o <= next_state == ST_RUN && !next_dir;
      speed_o       <= next_dir ? spd_open : spd_close;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || next_state != state) tmr <= 18'h00000;
    else if (ms_tick) tmr <= tmr + 18'h00001;
  end

  // redundant pairs: disagreement held past the interval is a fault
  assign pa = {rel_a_s, psd_a_s};
  assign pb = {rel_b_s, psd_b_s};
  for (genvar g = 0; g < 2; g++) begin : g_pair
    always_ff @(posedge clk_i) begin
      if (rst_i || pa[g] == pb[g]) begin
        mis_cnt[g] <= ZERO;
        fault[g]   <= 1'b0;
      end else begin
        if (ms_tick && mis_cnt[g] != LIM_MAX) mis_cnt[g] <= mis_cnt[g] + 10'h001;
        fault[g] <= mis_cnt[g] >= mism;
      end
    end
  end
  assign psd_ok = psd_a_s && psd_b_s && !fault[0];
  assign rel_ok = rel_a_s && rel_b_s && !fault[1];

  // shutdown input qualifies once, at a single threshold
  always_ff @(posedge clk_i) begin
    if (rst_i || !esd_s) esd_cnt <= ZERO;
    else if (ms_tick && esd_cnt != ESD_QUAL_MS) esd_cnt <= esd_cnt + 10'h001;
  end
  assign esd_hit = esd_s && ms_tick && esd_cnt == ESD_QUAL_MS - 10'h001;

  always_ff @(posedge clk_i) begin
    if (rst_i) esd_latch <= 1'b0;
    else if (esd_hit && !psd_ok) esd_latch <= 1'b1;
    else if (rel_ok) esd_latch <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) psd_test <= 1'b0;
    else if (esd_hit && psd_ok) psd_test <= 1'b1;
    else if (!psd_ok) psd_test <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      esd_active_o <= 1'b0;
      psd_test_o   <= 1'b0;
    end else begin
      esd_active_o <= esd_latch;
      psd_test_o   <= psd_test;
    end
  end

  // stored-energy ride-through and display sleep
  always_ff @(posedge clk_i) begin
    if (rst_i || !line_s) pwr_cnt <= 22'h000000;
    else if (ms_tick && pwr_cnt != 22'(HOUR_MS)) pwr_cnt <= pwr_cnt + 22'h000001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ride_ok       <= 1'b0;
      status_hold_o <= 1'b0;
    end else begin
      if (line_s) ride_ok <= pwr_cnt == 22'(HOUR_MS);
      status_hold_o <= line_s || ride_ok;
    end
  end

  // a position change with the motor off is handwheel motion
  always_ff @(posedge clk_i) begin
    if (rst_i) pos_q <= ZERO;
    else pos_q <= pos_i;
  end
  assign wake = knob_s || hand_s
                || (pos_q != pos_i && !drive_open_o && !drive_close_o);

  always_ff @(posedge clk_i) begin
    if (rst_i || line_s || wake) idle_ms <= 18'h00000;
    else if (ms_tick && idle_ms != 18'h3ffff) idle_ms <= idle_ms + 18'h00001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) display_on_o <= 1'b1;
    else display_on_o <= line_s || idle_ms < 18'(sleep) * SEC_MS;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_stopped;
    $fell(drive_open_o || drive_close_o) && dly != ZERO;
  endsequence
  sequence s_woken;
    wake && sleep != ZERO;
  endsequence

  a_one_direction: assert property (!(drive_open_o && drive_close_o))
    else $error("both drive outputs on");
  a_stop_delay: assert property (s_stopped |-> !(drive_open_o || drive_close_o) [*8])
    else $error("motor restarted inside stop delay");
  a_latch_hold: assert property (esd_latch && !rel_ok |=> esd_latch)
    else $error("shutdown cleared without release");
  a_latch_clear: assert property (esd_latch && rel_ok && !esd_hit |=> !esd_latch)
    else $error("release did not clear shutdown");
  a_rel_fault: assert property (esd_latch && fault[1] |=> esd_latch)
    else $error("faulted release cleared shutdown");
  a_esd_ignore: assert property ($rose(esd_latch) |-> $past(esd_s) && esd_cnt > ESD_IGN_MS
                                   && esd_cnt < ESD_LATCH_MS)
    else $error("shutdown latched outside qualifying window");
  a_stroke_test: assert property (psd_test && psd_ok |=> psd_test)
    else $error("stroke test ended while enabled");
  a_esd_direct: assert property (esd_latch && state == ST_RUN |=> state != ST_PAUSE)
    else $error("shutdown motion was pulsed");
  a_display_wake: assert property (s_woken |-> ##2 display_on_o)
    else $error("display did not wake");
  a_pair_fault: assert property (fault[0] |-> psd_a_s != psd_b_s)
    else $error("fault flagged on agreeing pair");

endmodule
`default_nettype wire

// ===== hdl/vac_pkg.sv
// constants, register map and types for the valve actuator motion control block
`default_nettype none
package vac_pkg;
  localparam int CLK_HZ      = 25_000_000;
  localparam int CLK_NS      = 1_000_000_000 / CLK_HZ;
  localparam int MS_NS       = 1_000_000;
  localparam int MS_CYC_DEF  = MS_NS / CLK_NS;
  localparam int HOUR_MS_DEF = 3_600_000;

  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_PBAND  = 8'h04;
  localparam logic [7:0] A_DBAND  = 8'h08;
  localparam logic [7:0] A_PRESET = 8'h0c;
  localparam logic [7:0] A_DELAY  = 8'h10;
  localparam logic [7:0] A_PLIM   = 8'h14;
  localparam logic [7:0] A_PON    = 8'h18;
  localparam logic [7:0] A_POFF   = 8'h1c;
  localparam logic [7:0] A_SPEED  = 8'h20;
  localparam logic [7:0] A_SLEEP  = 8'h24;
  localparam logic [7:0] A_MISM   = 8'h28;
  localparam logic [7:0] A_STATUS = 8'h2c;

  localparam int C_POL  = 0;
  localparam int C_LOSS = 1;
  localparam int C_PO   = 3;
  localparam int C_PC   = 4;
  localparam int C_ESD  = 5;
  localparam logic [7:0] CTRL_DEF = 8'h22;

  // travel in tenths of a percent; delay, pulse, sleep and mismatch limits in their timer units
  localparam logic [9:0] FULL     = 10'h3e8;
  localparam logic [9:0] ZERO     = 10'h000;
  localparam logic [9:0] PB_MIN   = 10'h001;
  localparam logic [9:0] PB_DEF   = 10'h096;
  localparam logic [9:0] DB_DEF   = 10'h014;
  localparam logic [9:0] EXT_LO   = 10'h014;
  localparam logic [9:0] EXT_HI   = 10'h3d4;
  localparam logic [9:0] PLIM_MIN = 10'h005;
  localparam logic [9:0] PLIM_MAX = 10'h3de;
  localparam logic [9:0] DLY_MAX  = 10'h03c;
  localparam logic [9:0] ON_MIN   = 10'h001;
  localparam logic [9:0] ON_MAX   = 10'h028;
  localparam logic [9:0] OFF_MIN  = 10'h001;
  localparam logic [9:0] OFF_MAX  = 10'h0c8;
  localparam logic [9:0] LIM_MAX  = 10'h3ff;
  localparam logic [9:0] SLEEP_DEF = 10'h01e;
  localparam logic [9:0] MISM_DEF = 10'h032;

  localparam logic [17:0] HALF_MS    = 18'h001f4;
  localparam logic [17:0] SEC_MS     = 18'h003e8;
  localparam logic [17:0] APP_ON_MS  = 18'h001f4;
  localparam logic [17:0] APP_OFF_MS = 18'h003e8;
  localparam logic [9:0]  ESD_IGN_MS   = 10'h064;
  localparam logic [9:0]  ESD_QUAL_MS  = 10'h190;
  localparam logic [9:0]  ESD_LATCH_MS = 10'h320;

  typedef enum logic [1:0] {
    ACT_OPEN = 2'h0, ACT_CLOSE = 2'h1, ACT_STOP = 2'h2, ACT_PRESET = 2'h3
  } vac_act_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_RUN = 4'h2, ST_PAUSE = 4'h4, ST_DELAY = 4'h8
  } vac_state_t;
endpackage
`default_nettype wire

// ===== sim/vac_plant.sv
// motor and encoder model: position follows the drive commands
`default_nettype none
module vac_plant #(
  parameter int STEP = 50
) (
  input  wire logic       clk_i,
  input  wire logic       drive_open_i,
  input  wire logic       drive_close_i,
  output var  logic [9:0] pos_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  initial pos_o = 10'h000;
  // slow travel so that approach pulsing is visible before arrival
  always @(posedge clk_i) begin
    cnt <= (cnt + 1) % STEP;
    if (cnt == 0 && drive_open_i && pos_o < 10'h3e8) pos_o <= pos_o + 10'h001;
    else if (cnt == 0 && drive_close_i && pos_o > 10'h000) pos_o <= pos_o - 10'h001;
  end
endmodule
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the valve actuator motion block
`default_nettype none
module tb
  import vac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [7:0]  a;
    logic        w;
    logic [31:0] d;
    logic [31:0] e;
  } vac_row_t;
  localparam int DOP = 0, DCL = 1, DSP = 2, HLD = 3, SHUT = 4, PST = 5;
  localparam vac_row_t ROWS [0:22] = '{
    '{A_STATUS, 1'b0, 32'h0, 32'h4},
    '{A_CTRL, 1'b0, 32'h0, 32'h22}, '{A_PBAND, 1'b0, 32'h0, 32'h96},
    '{A_DBAND, 1'b0, 32'h0, 32'h14}, '{A_DELAY, 1'b0, 32'h0, 32'h0},
    '{A_PLIM, 1'b0, 32'h0, 32'h3de}, '{A_PON, 1'b0, 32'h0, 32'h1},
    '{A_POFF, 1'b0, 32'h0, 32'h1}, '{A_SLEEP, 1'b0, 32'h0, 32'h1e},
    '{A_MISM, 1'b0, 32'h0, 32'h32}, '{A_PBAND, 1'b1, 32'h0, 32'h1},
    '{A_PBAND, 1'b1, 32'h3e8, 32'h3e8}, '{A_PBAND, 1'b1, 32'h96, 32'h96},
    '{A_DELAY, 1'b1, 32'h64, 32'h3c}, '{A_DELAY, 1'b1, 32'h0, 32'h0},
    '{A_PLIM, 1'b1, 32'h3e8, 32'h3de}, '{A_PLIM, 1'b1, 32'h0, 32'h5},
    '{A_PON, 1'b1, 32'h32, 32'h28}, '{A_POFF, 1'b1, 32'h12c, 32'hc8},
    '{A_POFF, 1'b1, 32'h1, 32'h1}, '{A_SPEED, 1'b1, 32'h5a3c, 32'h5a3c},
    '{A_SLEEP, 1'b1, 32'h1, 32'h1}, '{8'h30, 1'b1, 32'hffff, 32'h0}
  };
  logic        clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [7:0]  adr_i = 8'h00;
  logic [31:0] dat_i = 32'h0, rdat;
  logic [3:0]  sel_i = 4'hf;
  logic [9:0]  cmd_i = 10'h000;
  logic        cmd_ok_i = 1'b1, esd_mom_i = 1'b0, psd_en_a_i = 1'b0, psd_en_b_i = 1'b0;
  logic        rel_a_i = 1'b0, rel_b_i = 1'b0, knob_open_i = 1'b0, handwheel_i = 1'b0;
  logic        line_power_i = 1'b0;
  logic [31:0] dat_o;
  logic [9:0]  pos_i;
  logic [7:0]  speed_o;
  logic        ack_o, drive_open_o, drive_close_o, display_on_o, status_hold_o;
  logic        esd_active_o, psd_test_o;
  logic [5:0]  outs;
  int          failures = 0, tests_run = 0;
  assign outs = {psd_test_o, esd_active_o, status_hold_o, display_on_o, drive_close_o,
                 drive_open_o};

  vac_motion #(.MS_CYC(10), .HOUR_MS(50)) i_vac_motion (.clk_i, .rst_i, .adr_i, .dat_i,
    .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .cmd_i, .cmd_ok_i, .pos_i, .esd_mom_i,
    .psd_en_a_i, .psd_en_b_i, .rel_a_i, .rel_b_i, .knob_open_i, .handwheel_i,
    .line_power_i, .drive_open_o, .drive_close_o, .speed_o, .display_on_o,
    .status_hold_o, .esd_active_o, .psd_test_o);
  vac_plant #(.STEP(50)) i_vac_plant (.clk_i, .drive_open_i(drive_open_o),
    .drive_close_i(drive_close_o), .pos_o(pos_i));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; request held until ack is sampled high at a rising edge
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    adr_i <= a;
    we_i <= w;
    dat_i <= d;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    do @(posedge clk_i); while (ack_o !== 1'b1 && ++n < 50);
    if (n >= 50) failures++;
    rdat = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // stay=1: output must hold v for lim cycles; stay=0: must reach v within lim
  task automatic watch(input int s, input logic v, input int lim, input bit stay);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((stay ? outs[s] === v : outs[s] !== v) && n < lim);
    chk({31'h0, outs[s]}, {31'h0, v});
    @(posedge clk_i);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (95000) @(posedge clk_i);
    failures++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({26'h0, outs}, 32'h4);
    @(posedge clk_i);
    foreach (ROWS[i]) begin
      if (ROWS[i].w) wb(ROWS[i].a, 1'b1, ROWS[i].d);
      wb(ROWS[i].a, 1'b0, 32'h0);
      chk(rdat, ROWS[i].e);
    end
    line_power_i <= 1'b1;
    watch(HLD, 1'b1, 20, 1'b0);
    line_power_i <= 1'b0;
    watch(HLD, 1'b0, 10, 1'b0);
    line_power_i <= 1'b1;
    repeat (700) @(posedge clk_i);
    line_power_i <= 1'b0;
    watch(HLD, 1'b1, 100, 1'b1);
    watch(DSP, 1'b1, 5000, 1'b1);
    watch(DSP, 1'b0, 8000, 1'b0);
    knob_open_i <= 1'b1;
    watch(DSP, 1'b1, 10, 1'b0);
    knob_open_i <= 1'b0;
    watch(DSP, 1'b0, 12000, 1'b0);
    handwheel_i <= 1'b1;
    watch(DSP, 1'b1, 10, 1'b0);
    handwheel_i <= 1'b0;
    line_power_i <= 1'b1;
    // travel into the top end zone from just outside the approach band
    cmd_i <= 10'h3e8;
    i_vac_plant.pos_o <= 10'h348;
    watch(DOP, 1'b1, 10, 1'b0);
    chk({24'h0, speed_o}, 32'h3c);
    watch(DOP, 1'b1, 7500, 1'b1);
    watch(DOP, 1'b0, 1000, 1'b0);
    cmd_i <= 10'h1f4;
    i_vac_plant.pos_o <= 10'h2bc;
    watch(DCL, 1'b1, 10, 1'b0);
    chk({24'h0, speed_o}, 32'h5a);
    watch(DCL, 1'b0, 8000, 1'b0);
    chk({31'h0, pos_i > 10'h208}, 32'h1);
    cmd_ok_i <= 1'b0;
    watch(DCL, 1'b1, 12000, 1'b0);
    cmd_ok_i <= 1'b1;
    cmd_i <= 10'h000;
    wb(A_CTRL, 1'b1, 32'h23);
    watch(DOP, 1'b1, 12000, 1'b0);
    wb(A_CTRL, 1'b1, 32'h22);
    esd_mom_i <= 1'b1;
    repeat (500) @(posedge clk_i);
    esd_mom_i <= 1'b0;
    watch(SHUT, 1'b0, 4500, 1'b1);
    esd_mom_i <= 1'b1;
    watch(SHUT, 1'b1, 9000, 1'b0);
    esd_mom_i <= 1'b0;
    watch(DCL, 1'b1, 20, 1'b0);
    watch(SHUT, 1'b1, 600, 1'b1);
    rel_a_i <= 1'b1;
    watch(SHUT, 1'b1, 1500, 1'b1);
    rel_b_i <= 1'b1;
    watch(SHUT, 1'b0, 50, 1'b0);
    rel_a_i <= 1'b0;
    rel_b_i <= 1'b0;
    psd_en_a_i <= 1'b1;
    psd_en_b_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    esd_mom_i <= 1'b1;
    watch(PST, 1'b1, 9000, 1'b0);
    chk({31'h0, esd_active_o}, 32'h0);
    esd_mom_i <= 1'b0;
    rel_a_i <= 1'b1;
    rel_b_i <= 1'b1;
    watch(PST, 1'b1, 200, 1'b1);
    psd_en_a_i <= 1'b0;
    psd_en_b_i <= 1'b0;
    watch(PST, 1'b0, 20, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
